// ---- src/ddrsp_pkg.sv ----
// Shared constants and types of the burst-of-two common-I/O memory port
package ddrsp_pkg;
   // Organisation select: 1 gives 1M x 36, 0 gives 2M x 18
   localparam int ORG_X36 = 1;
   localparam int DQ_W = (ORG_X36 != 0) ? 36 : 18;
   localparam int LANE_W = 9;
   localparam int LANES = DQ_W / LANE_W;
   // One address selects a pair of beats, so one bit less than the word count
   localparam int ADDR_W = (ORG_X36 != 0) ? 19 : 20;
   localparam int PAIRS = 2 ** ADDR_W;
   // Late-write buffer
   localparam int WBUF_DEPTH = 16;
   localparam int WBUF_AW = 4;
   // Buffer entry layout, low to high: mask1, data1, mask0, data0, address
   localparam int OFF_M1 = 0;
   localparam int OFF_D1 = OFF_M1 + LANES;
   localparam int OFF_M0 = OFF_D1 + DQ_W;
   localparam int OFF_D0 = OFF_M0 + LANES;
   localparam int OFF_A = OFF_D0 + DQ_W;
   localparam int WBUF_W = OFF_A + ADDR_W;
   // Lock wait of the delay line after it is enabled, in mclk cycles
   localparam int LOCK_W = 12;
   localparam logic [LOCK_W-1:0] DLL_LOCK_CYC = 12'h800;
   localparam logic [1:0] SYNC_RST = 2'h0;
   typedef logic [DQ_W-1:0] ddrsp_dq_t;
   typedef logic [ADDR_W-1:0] ddrsp_addr_t;
   typedef logic [LANES-1:0] ddrsp_mask_t;
   typedef logic [WBUF_W-1:0] ddrsp_ent_t;
endpackage

// ---- src/ddrsp_port.sv ----
// Late-write buffer and the memory port core with its link-side timing
`timescale 1ns/1ps

// Synchronous FIFO with a view of every slot for write forwarding
module ddrsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [WIDTH*DEPTH-1:0] peek_data,
   output logic [AW-1:0] peek_rd,
   output logic [AW:0] peek_cnt
);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } ddrsp_fifo_s;

   ddrsp_fifo_s st_ff;
   ddrsp_fifo_s nxt_st;
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic push;
   logic pop;

   // Honest flags: full refuses, empty offers nothing
   assign in_ready = st_ff.cnt != (AW + 1)'(DEPTH);
   assign out_valid = st_ff.cnt != '0;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[st_ff.rd];
   assign peek_rd = st_ff.rd;
   assign peek_cnt = st_ff.cnt;

   for (genvar i = 0; i < DEPTH; i++) begin : g_peek
      assign peek_data[i*WIDTH +: WIDTH] = mem[i];
   end

   // Pointer and count update; depth is a power of two so pointers wrap
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.wr = st_ff.wr + 1'b1;
      end
      if (pop) begin
         nxt_st.rd = st_ff.rd + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Storage holds no reset; slots are only read once written
   always_ff @(posedge clk) begin
      if (push) begin
         mem[st_ff.wr] <= in_data;
      end
   end
endmodule

// How it works
// RL1: Array is 1M x 36 or 2M x 18; data width follows organisation.
// RL2: Every read and write moves exactly two beats; no other burst length.
// RL3: Address and command are taken only on the true clock rising edge.
// RL4: Each command edge carries its own address; reads and writes may alternate.
// RL5: First write beat and masks taken one true-clock cycle after the write.
// RL6: Second write beat and masks taken on the next complement-clock edge.
// RL7: Each beat carries its own masks; each bit governs its byte for that beat.
// RL8: Write data waits in an internal buffer; the array write happens later itself.
// RL9: First read beat appears on the third complement edge, 2.5 cycles after.
// RL10: Second read beat appears on the fourth true edge, counting the command edge.
// RL11: Echo clock pair toggles with the outgoing read data.
// RL12: One shared data bus; driven only during read beats, received for writes.
// RL13: Reads of buffered writes return new bytes merged over stored bytes.
// RL14: Load strobe low starts a cycle; select high reads, low writes.
// RL15: Mask bit low writes its byte; high leaves that byte unchanged.
// RL16: Read-valid flag marks read beats, changing with the echo clock edges.
// RL17: Delay line off or unlocked: reset, bypassed, read latency one cycle shorter.
module ddrsp_port (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic k_clk,
   input wire logic cycle_load_n,
   input wire logic read_write_n,
   input wire ddrsp_pkg::ddrsp_addr_t word_address,
   input wire ddrsp_pkg::ddrsp_mask_t byte_lane_write_n,
   input wire ddrsp_pkg::ddrsp_dq_t dq_i,
   output ddrsp_pkg::ddrsp_dq_t dq_o,
   output logic dq_oe_n,
   output logic echo_clock_true,
   output logic echo_clock_comp,
   output logic read_beat_valid,
   input wire logic dll_off_n,
   output logic dll_locked,
   output logic wbuf_ready
);
   // State registered on the rising true-clock edge
   typedef struct packed {
      logic rd_v;
      ddrsp_pkg::ddrsp_addr_t rd_a;
      logic wr_v;
      ddrsp_pkg::ddrsp_addr_t wr_a;
      logic wd_v;
      ddrsp_pkg::ddrsp_addr_t wd_a;
      ddrsp_pkg::ddrsp_dq_t d0;
      ddrsp_pkg::ddrsp_mask_t m0;
      logic v1;
      ddrsp_pkg::ddrsp_dq_t r0;
      ddrsp_pkg::ddrsp_dq_t r1;
      logic v2;
      ddrsp_pkg::ddrsp_dq_t s0;
      ddrsp_pkg::ddrsp_dq_t s1;
      logic q_v;
      ddrsp_pkg::ddrsp_dq_t q1;
      logic tp;
      logic [1:0] lk;
   } ddrsp_pos_s;

   // State registered on the falling edge, which is the complement rising edge
   typedef struct packed {
      ddrsp_pkg::ddrsp_dq_t d1;
      ddrsp_pkg::ddrsp_mask_t m1;
      logic q_v;
      ddrsp_pkg::ddrsp_dq_t q0;
      logic tn;
   } ddrsp_neg_s;

   // Delay-line emulation on the system clock
   typedef struct packed {
      logic [1:0] sy;
      logic [ddrsp_pkg::LOCK_W-1:0] cnt;
      logic lock;
   } ddrsp_sys_s;

   ddrsp_pos_s pos_ff;
   ddrsp_pos_s nxt_pos;
   ddrsp_neg_s neg_ff;
   ddrsp_neg_s nxt_neg;
   ddrsp_sys_s sys_ff;
   ddrsp_sys_s nxt_sys;

   logic short_lat;
   logic phase;
   logic drain;
   logic buf_valid;
   ddrsp_pkg::ddrsp_ent_t push_ent;
   ddrsp_pkg::ddrsp_ent_t head_ent;
   logic [ddrsp_pkg::WBUF_W*ddrsp_pkg::WBUF_DEPTH-1:0] peek_data;
   logic [ddrsp_pkg::WBUF_AW-1:0] peek_rd;
   logic [ddrsp_pkg::WBUF_AW:0] peek_cnt;
   ddrsp_pkg::ddrsp_dq_t rd0_w;
   ddrsp_pkg::ddrsp_dq_t rd1_w;

   // Unlocked or bypassed delay line selects the shorter read pipeline
   assign short_lat = ~pos_ff.lk[1]; // RL17

   // Both beats of a write leave together as one buffer entry
   assign push_ent = {pos_ff.wd_a, pos_ff.d0, pos_ff.m0, neg_ff.d1, neg_ff.m1}; // RL2 RL8

   // Array port serves the read stage first; buffered writes wait for a free edge
   assign drain = buf_valid & ~pos_ff.rd_v; // RL8

   ddrsp_fifo #(
      .WIDTH(ddrsp_pkg::WBUF_W),
      .DEPTH(ddrsp_pkg::WBUF_DEPTH),
      .AW(ddrsp_pkg::WBUF_AW)
   ) u_wbuf (
      .clk(k_clk),
      .rst_n(nrst),
      .in_valid(pos_ff.wd_v),
      .in_ready(wbuf_ready),
      .in_data(push_ent),
      .out_valid(buf_valid),
      .out_ready(drain),
      .out_data(head_ent),
      .peek_data(peek_data),
      .peek_rd(peek_rd),
      .peek_cnt(peek_cnt)
   );

   // Per byte lane: storage, late write and forwarding from pending writes
   for (genvar l = 0; l < ddrsp_pkg::LANES; l++) begin : g_lane
      logic [ddrsp_pkg::LANE_W-1:0] mem_b0 [0:ddrsp_pkg::PAIRS-1]; // RL1
      logic [ddrsp_pkg::LANE_W-1:0] mem_b1 [0:ddrsp_pkg::PAIRS-1];
      localparam int D0 = ddrsp_pkg::OFF_D0 + l * ddrsp_pkg::LANE_W;
      localparam int D1 = ddrsp_pkg::OFF_D1 + l * ddrsp_pkg::LANE_W;
      localparam int M0 = ddrsp_pkg::OFF_M0 + l;
      localparam int M1 = ddrsp_pkg::OFF_M1 + l;

      // Low mask bit writes the byte of its own beat
      always_ff @(posedge k_clk) begin
         if (drain) begin
            if (!head_ent[M0]) begin // RL15 RL7
               mem_b0[head_ent[ddrsp_pkg::OFF_A +: ddrsp_pkg::ADDR_W]] <= head_ent[D0 +: 9];
            end
            if (!head_ent[M1]) begin // RL15 RL7
               mem_b1[head_ent[ddrsp_pkg::OFF_A +: ddrsp_pkg::ADDR_W]] <= head_ent[D1 +: 9];
            end
         end
      end

      // Oldest to newest overlay, so the latest write of a byte wins
      always_comb begin
         logic [ddrsp_pkg::WBUF_AW-1:0] idx;
         ddrsp_pkg::ddrsp_ent_t ent;
         logic [ddrsp_pkg::LANE_W-1:0] b0;
         logic [ddrsp_pkg::LANE_W-1:0] b1;
         idx = '0;
         ent = '0;
         b0 = mem_b0[pos_ff.rd_a];
         b1 = mem_b1[pos_ff.rd_a];
         for (int i = 0; i < ddrsp_pkg::WBUF_DEPTH; i++) begin
            idx = peek_rd + ddrsp_pkg::WBUF_AW'(i);
            ent = peek_data[idx*ddrsp_pkg::WBUF_W +: ddrsp_pkg::WBUF_W];
            if ((ddrsp_pkg::WBUF_AW + 1)'(i) < peek_cnt
                  && ent[ddrsp_pkg::OFF_A +: ddrsp_pkg::ADDR_W] == pos_ff.rd_a) begin
               if (!ent[M0]) begin
                  b0 = ent[D0 +: 9]; // RL13
               end
               if (!ent[M1]) begin
                  b1 = ent[D1 +: 9]; // RL13
               end
            end
         end
         // Entry being pushed on this very edge is the newest of all
         if (pos_ff.wd_v && pos_ff.wd_a == pos_ff.rd_a) begin
            if (!push_ent[M0]) begin
               b0 = push_ent[D0 +: 9]; // RL13
            end
            if (!push_ent[M1]) begin
               b1 = push_ent[D1 +: 9]; // RL13
            end
         end
         rd0_w[l*ddrsp_pkg::LANE_W +: ddrsp_pkg::LANE_W] = b0;
         rd1_w[l*ddrsp_pkg::LANE_W +: ddrsp_pkg::LANE_W] = b1;
      end
   end

   // Rising true edge: command capture, write beat 0, read pipeline, beat 1 out
   always_comb begin
      nxt_pos = pos_ff;
      nxt_pos.rd_v = ~cycle_load_n & read_write_n; // RL3 RL14
      nxt_pos.rd_a = word_address; // RL4
      nxt_pos.wr_v = ~cycle_load_n & ~read_write_n; // RL3 RL14
      nxt_pos.wr_a = word_address; // RL4
      nxt_pos.wd_v = pos_ff.wr_v;
      nxt_pos.wd_a = pos_ff.wr_a;
      nxt_pos.d0 = dq_i; // RL5
      nxt_pos.m0 = byte_lane_write_n; // RL5
      nxt_pos.v1 = pos_ff.rd_v;
      nxt_pos.r0 = rd0_w;
      nxt_pos.r1 = rd1_w;
      nxt_pos.v2 = pos_ff.v1;
      nxt_pos.s0 = pos_ff.r0;
      nxt_pos.s1 = pos_ff.r1;
      nxt_pos.q_v = short_lat ? pos_ff.v1 : pos_ff.v2; // RL10 RL17
      nxt_pos.q1 = short_lat ? pos_ff.r1 : pos_ff.s1; // RL10
      nxt_pos.tp = ~pos_ff.tp;
      // Lock level arrives from the system clock through two flops
      nxt_pos.lk = {pos_ff.lk[0], sys_ff.lock};
   end

   always_ff @(posedge k_clk or negedge nrst) begin
      if (!nrst) begin
         pos_ff <= '0;
      end else begin
         pos_ff <= nxt_pos;
      end
   end

   // Complement edge: write beat 1 and read beat 0
   always_comb begin
      nxt_neg = neg_ff;
      nxt_neg.d1 = dq_i; // RL6
      nxt_neg.m1 = byte_lane_write_n; // RL6
      nxt_neg.q_v = short_lat ? pos_ff.v1 : pos_ff.v2; // RL9 RL17
      nxt_neg.q0 = short_lat ? pos_ff.r0 : pos_ff.s0; // RL9
      nxt_neg.tn = pos_ff.tp; // Copy, not toggle: a first edge that falls keeps phase low
   end

   always_ff @(negedge k_clk or negedge nrst) begin
      if (!nrst) begin
         neg_ff <= '0;
      end else begin
         neg_ff <= nxt_neg;
      end
   end

   // Delay line held in reset while disabled, then counts its lock time
   always_comb begin
      nxt_sys = sys_ff;
      nxt_sys.sy = {sys_ff.sy[0], dll_off_n};
      if (!sys_ff.sy[1]) begin
         nxt_sys.cnt = '0; // RL17
         nxt_sys.lock = 1'b0; // RL17
      end else if (sys_ff.cnt != ddrsp_pkg::DLL_LOCK_CYC) begin
         nxt_sys.cnt = sys_ff.cnt + 1'b1;
      end else begin
         nxt_sys.lock = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sys_ff <= '0;
      end else begin
         sys_ff <= nxt_sys;
      end
   end

   assign dll_locked = sys_ff.lock;

   // Echo clock follows the link clock, rebuilt from one flop per edge
   assign phase = pos_ff.tp ^ neg_ff.tn;
   assign echo_clock_true = phase; // RL11
   assign echo_clock_comp = ~phase; // RL11

   // Half after a falling edge shows beat 0, half after a rising edge beat 1
   assign read_beat_valid = phase ? pos_ff.q_v : neg_ff.q_v; // RL16
   assign dq_o = phase ? pos_ff.q1 : neg_ff.q0;
   // Bus released whenever no read beat is out, so write beats can come in
   assign dq_oe_n = ~read_beat_valid; // RL12
endmodule

// ---- test/ddrsp_port_assertions.sv ----
// Link and delay-line timing checks of the memory port
`timescale 1ns/1ps
module ddrsp_chk (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic k_clk,
   input wire logic cycle_load_n,
   input wire logic read_write_n,
   input wire logic dq_oe_n,
   input wire logic echo_clock_true,
   input wire logic echo_clock_comp,
   input wire logic read_beat_valid,
   input wire logic dll_off_n,
   input wire logic dll_locked
);
   logic rd_cmd;
   // Read request seen at a true-clock rise
   assign rd_cmd = !cycle_load_n && read_write_n;
   // Read after a quiet rise, delay line steady, so only this read can own the beats
   sequence s_rd_lk;
      dll_locked[*3] ##0 !rd_cmd ##1 dll_locked && rd_cmd;
   endsequence
   sequence s_rd_un;
      (!dll_locked)[*3] ##0 !rd_cmd ##1 !dll_locked && rd_cmd;
   endsequence
   AST_ECHO_RISE: assert property (@(posedge k_clk) disable iff (!nrst)
      !echo_clock_true && echo_clock_comp) else $error("echo pair wrong at rise");
   AST_ECHO_FALL: assert property (@(negedge k_clk) disable iff (!nrst)
      $past(nrst, 2) |-> echo_clock_true && !echo_clock_comp) else $error("echo pair wrong at fall");
   AST_OE_VALID: assert property (@(k_clk) disable iff (!nrst)
      dq_oe_n == !read_beat_valid) else $error("bus enable and valid disagree");
   AST_RD_LONG: assert property (@(posedge k_clk) disable iff (!nrst)
      s_rd_lk |-> ##2 !read_beat_valid ##1 read_beat_valid) else $error("long read latency wrong");
   AST_RD_SHORT: assert property (@(posedge k_clk) disable iff (!nrst)
      s_rd_un |-> ##1 !read_beat_valid ##1 read_beat_valid) else $error("short read latency wrong");
   AST_IDLE_QUIET: assert property (@(posedge k_clk) disable iff (!nrst)
      (!rd_cmd)[*3] |=> !read_beat_valid && dq_oe_n) else $error("bus driven without a read");
   AST_DLL_DROP: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(dll_off_n) |-> ##[1:3] !dll_locked) else $error("lock kept after delay line off");
   AST_LOCK_RISE: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(dll_locked) |-> $past(dll_off_n, 3)) else $error("lock while delay line off");
endmodule
bind ddrsp_port ddrsp_chk ddrsp_chk_i (.mclk, .nrst, .k_clk, .cycle_load_n, .read_write_n,
   .dq_oe_n, .echo_clock_true, .echo_clock_comp, .read_beat_valid, .dll_off_n, .dll_locked);

// ---- test/ddrsp_ctl_model.sv ----
// Controller model on the far side of the memory link
`timescale 1ns/1ps
module ddrsp_ctl (
   input wire logic k_clk,
   input wire ddrsp_pkg::ddrsp_dq_t dq_o,
   input wire logic dq_oe_n,
   output logic cycle_load_n,
   output logic read_write_n,
   output ddrsp_pkg::ddrsp_addr_t word_address,
   output ddrsp_pkg::ddrsp_mask_t byte_lane_write_n,
   output ddrsp_pkg::ddrsp_dq_t dq_i
);
   ddrsp_pkg::ddrsp_dq_t wdat;
   logic wen;
   // Released bus shows the inverse of our last beat, so stale data cannot pass
   assign dq_i = !dq_oe_n ? dq_o : (wen ? wdat : ~wdat);
   initial begin
      {cycle_load_n, read_write_n, wen} = 3'h6;
      word_address = '0;
      byte_lane_write_n = '1;
      wdat = '0;
   end
   // Strobe lasts one rise; the release lands after that rise sampled it
   always @(posedge k_clk) cycle_load_n <= 1'b1;
   // Write: command, beat0 one cycle later, beat1 on the following fall
   task automatic wr(input ddrsp_pkg::ddrsp_addr_t a, input ddrsp_pkg::ddrsp_dq_t d0,
      input ddrsp_pkg::ddrsp_mask_t m0, input ddrsp_pkg::ddrsp_dq_t d1,
      input ddrsp_pkg::ddrsp_mask_t m1);
      @(negedge k_clk);
      cycle_load_n = 1'b0;
      read_write_n = 1'b0;
      word_address = a;
      @(negedge k_clk);
      wdat = d0;
      byte_lane_write_n = m0;
      wen = 1'b1;
      @(posedge k_clk);
      wdat <= d1;
      byte_lane_write_n <= m1;
      @(negedge k_clk);
      wen <= 1'b0;
      byte_lane_write_n <= '1;
   endtask
   // Read: lat+1 rises, the command rise included, pass before the fall that opens beat0; sampled mid half-cycle
   task automatic rd(input ddrsp_pkg::ddrsp_addr_t a, input int lat,
      output ddrsp_pkg::ddrsp_dq_t q0, output ddrsp_pkg::ddrsp_dq_t q1);
      @(negedge k_clk);
      cycle_load_n = 1'b0;
      read_write_n = 1'b1;
      word_address = a;
      repeat (lat + 1) @(posedge k_clk);
      @(negedge k_clk);
      #16;
      q0 = dq_o;
      @(posedge k_clk);
      #16;
      q1 = dq_o;
   endtask
endmodule

// ---- test/ddrsp_port_tb.sv ----
// Self-checking bench of the memory port: latency, masks, merge, delay line
`timescale 1ns/1ps
module ddrsp_port_tb;
   logic mclk, nrst, k_clk, dll_off_n, cycle_load_n, read_write_n, dq_oe_n;
   logic echo_clock_true, echo_clock_comp, read_beat_valid, dll_locked, wbuf_ready;
   ddrsp_pkg::ddrsp_addr_t word_address;
   ddrsp_pkg::ddrsp_mask_t byte_lane_write_n;
   ddrsp_pkg::ddrsp_dq_t dq_i, dq_o, q0, q1, p0, p1, e0, e1;
   int failures, cmp_count;
   localparam int LW = ddrsp_pkg::LANE_W;
   localparam ddrsp_pkg::ddrsp_addr_t AD_A = 19'h00005, AD_B = 19'h7FFFF;
   localparam ddrsp_pkg::ddrsp_dq_t A0 = 36'h123456789, A1 = 36'hABCDEF012;
   localparam ddrsp_pkg::ddrsp_dq_t B0 = 36'h0F0F0F0F0, B1 = 36'h555555555;
   localparam ddrsp_pkg::ddrsp_dq_t N0 = 36'hFFFFFFFFF, N1 = 36'h000000000;
   ddrsp_port ddrsp_port_i (.mclk, .nrst, .k_clk, .cycle_load_n, .read_write_n, .word_address,
      .byte_lane_write_n, .dq_i, .dq_o, .dq_oe_n, .echo_clock_true, .echo_clock_comp,
      .read_beat_valid, .dll_off_n, .dll_locked, .wbuf_ready);
   ddrsp_ctl ddrsp_ctl_i (.k_clk, .dq_o, .dq_oe_n, .cycle_load_n, .read_write_n,
      .word_address, .byte_lane_write_n, .dq_i);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Link clock offset so its edges never line up with the system clock
   initial begin
      k_clk = 1'b0;
      #7;
      forever #32 k_clk = ~k_clk;
   end
   task automatic chk_dq(input string what, input ddrsp_pkg::ddrsp_dq_t exp,
      input ddrsp_pkg::ddrsp_dq_t got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask
   // Byte lanes with a low mask bit take the new data
   function automatic ddrsp_pkg::ddrsp_dq_t merge(input ddrsp_pkg::ddrsp_dq_t old,
      input ddrsp_pkg::ddrsp_dq_t nw, input ddrsp_pkg::ddrsp_mask_t m);
      merge = old;
      for (int i = 0; i < ddrsp_pkg::LANES; i++)
         if (!m[i]) merge[i*LW +: LW] = nw[i*LW +: LW];
   endfunction
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      chk_bit("dq_oe_n", 1'b1, dq_oe_n);
      chk_bit("valid", 1'b0, read_beat_valid);
      chk_bit("echo true", 1'b0, echo_clock_true);
      chk_bit("echo comp", 1'b1, echo_clock_comp);
      chk_bit("locked", 1'b0, dll_locked);
      chk_bit("wbuf_ready", 1'b1, wbuf_ready);
      $display("reset test done");
   endtask
   // Delay line held off: reads come back one cycle early
   task automatic t_short;
      ddrsp_ctl_i.wr(AD_A, A0, 4'h0, A1, 4'h0);
      ddrsp_ctl_i.wr(AD_B, B0, 4'h0, B1, 4'h0);
      ddrsp_ctl_i.rd(AD_A, 1, q0, q1);
      chk_dq("short beat0", A0, q0);
      chk_dq("short beat1", A1, q1);
      $display("short latency test done");
   endtask
   task automatic t_lock;
      int n;
      @(negedge mclk);
      dll_off_n = 1'b1;
      n = 0;
      while (dll_locked !== 1'b1 && n < 2200) begin
         @(negedge mclk);
         n++;
      end
      chk_bit("locked", 1'b1, dll_locked);
      repeat (4) @(posedge k_clk);
      $display("lock test done");
   endtask
   // Partial write with differing masks, read on the very next rise
   task automatic t_merge;
      e0 = merge(A0, N0, 4'h5);
      e1 = merge(A1, N1, 4'hA);
      fork
         ddrsp_ctl_i.wr(AD_A, N0, 4'h5, N1, 4'hA);
         begin
            @(negedge k_clk);
            ddrsp_ctl_i.rd(AD_A, 2, q0, q1);
         end
      join
      chk_dq("fwd beat0", e0, q0);
      chk_dq("fwd beat1", e1, q1);
      repeat (4) @(posedge k_clk);
      ddrsp_ctl_i.rd(AD_A, 2, q0, q1);
      chk_dq("array beat0", e0, q0);
      chk_dq("array beat1", e1, q1);
      $display("merge test done");
   endtask
   task automatic t_b2b;
      fork
         ddrsp_ctl_i.rd(AD_B, 2, q0, q1);
         begin
            @(negedge k_clk);
            ddrsp_ctl_i.rd(AD_A, 2, p0, p1);
         end
      join
      chk_dq("b2b first beat0", B0, q0);
      chk_dq("b2b first beat1", B1, q1);
      chk_dq("b2b second beat0", e0, p0);
      chk_dq("b2b second beat1", e1, p1);
      $display("back to back test done");
   endtask
   task automatic t_off;
      @(negedge mclk);
      dll_off_n = 1'b0;
      repeat (4) @(negedge mclk);
      chk_bit("unlocked", 1'b0, dll_locked);
      $display("delay line off test done");
   endtask
   // Lock wait dominates the run; this allows about five times that span
   initial begin
      #1000000;
      failures++;
      test_done;
   end
   initial begin
      {nrst, dll_off_n} = 2'h0;
      failures = 0;
      cmp_count = 0;
      repeat (3) @(negedge mclk);
      t_reset;
      nrst = 1'b1;
      t_short;
      t_lock;
      t_merge;
      t_b2b;
      t_off;
      test_done;
   end
endmodule
